// *** include/sdfmon_pkg.sv ***
// Package for the sigma-delta comparator monitor
package sdfmon_pkg;
    localparam int          DATA_W        = 16;
    localparam int          CLKFAIL_CYC   = 256;
    localparam logic [8:0]  CLKFAIL_LAST  = 9'(CLKFAIL_CYC - 1);
    localparam logic [1:0]  ORD_SINC1     = 2'h0;
    localparam logic [1:0]  ORD_SINC2     = 2'h1;
    localparam logic [1:0]  ORD_SINC3     = 2'h2;
    localparam logic [7:0]  OSR_RST       = 8'h00;
    localparam logic [DATA_W-1:0] THR_MIN = 16'h0000;
    localparam logic [DATA_W-1:0] THR_MAX = 16'hFFFF;
    localparam int          FLAG_HI       = 0;
    localparam int          FLAG_LO       = 1;
    localparam int          FLAG_ZC       = 2;
    localparam int          FLAG_CF       = 3;
    localparam int          NFLAG         = 4;

    typedef struct packed {
        logic [DATA_W-1:0] high;
        logic [DATA_W-1:0] low;
        logic [DATA_W-1:0] zero;
    } sdfmon_thr_t;

    typedef struct packed {
        logic [1:0] order;
        logic [7:0] osr;
    } sdfmon_cfg_t;
endpackage

// *** rtl/sdfmon_top.sv ***
// Sigma-delta comparator filter, thresholds and modulator clock monitor
// Operation
// - The bitstream goes through a sinc comparator filter compared to high, low and zero thresholds.
// - A result above the high or below the low limit raises the interrupt.
// - No modulator clock edge for 256 system clocks flags clock fail and interrupts.
// - High threshold at minimum with low at maximum forces the interrupt.
// - The primary filter produces a result word software can check.
`timescale 1ns/1ps
module sdfmon_top
    import sdfmon_pkg::*;
(
    // Clock and reset
    input  wire logic                 CORE_CLK,
    input  wire logic                 SYS_RST,
    // Modulator link
    input  wire logic                 MOD_CLK,
    input  wire logic                 MOD_DATA,
    // Configuration
    input  wire sdfmon_pkg::sdfmon_cfg_t CMP_CFG,
    input  wire sdfmon_pkg::sdfmon_cfg_t PRI_CFG,
    input  wire sdfmon_pkg::sdfmon_thr_t THR,
    input  wire logic [sdfmon_pkg::NFLAG-1:0] FLAG_EN,
    input  wire logic [sdfmon_pkg::NFLAG-1:0] FLAG_CLR,
    // Status
    output logic [sdfmon_pkg::NFLAG-1:0] FLAG,
    output logic [sdfmon_pkg::DATA_W-1:0] CMP_DATA,
    output logic [sdfmon_pkg::DATA_W-1:0] PRI_DATA,
    output logic                      PRI_VALID,
    output logic                      IRQ
);
    import sdfmon_pkg::*;

    typedef struct packed {
        logic [31:0] i1, i2, i3;
        logic [31:0] d1, d2, d3;
        logic [7:0]  cnt;
    } sdfmon_sinc_t;

    // Integrate one sample, decimate per osr
    function automatic sdfmon_sinc_t sinc_step(input sdfmon_sinc_t s,
                                                input logic bit_in,
                                                input sdfmon_cfg_t c,
                                                output logic done,
                                                output logic [31:0] res);
        sdfmon_sinc_t n;
        logic [31:0]  x, v, c1, c2, c3;
        n = s;
        x = bit_in ? 32'h00000001 : 32'h00000000;
        n.i1 = s.i1 + x;
        n.i2 = s.i2 + n.i1;
        n.i3 = s.i3 + n.i2;
        done = (s.cnt == c.osr);
        res = 32'h00000000;
        v = 32'h00000000;
        c1 = 32'h00000000;
        c2 = 32'h00000000;
        c3 = 32'h00000000;
        if (done) begin
            n.cnt = 8'h00;
            // Integrator tap per order, then one comb stage per order
            unique case (c.order)
                ORD_SINC1: v = n.i1;
                ORD_SINC2: v = n.i2;
                default:   v = n.i3;
            endcase
            c1 = v - s.d1;
            c2 = c1 - s.d2;
            c3 = c2 - s.d3;
            n.d1 = v;
            n.d2 = c1;
            n.d3 = c2;
            unique case (c.order)
                ORD_SINC1: res = c1;
                ORD_SINC2: res = c2;
                default:   res = c3;
            endcase
        end else begin
            n.cnt = s.cnt + 8'h01;
        end
        return n;
    endfunction

    // Link synchronisers
    logic [1:0] mclk_sync_r, mclk_sync_nxt;
    logic [1:0] mdat_sync_r, mdat_sync_nxt;
    logic       mclk_prev_r, mclk_prev_nxt;
    logic       mod_edge;

    always_comb begin
        mclk_sync_nxt = {mclk_sync_r[0], MOD_CLK};
        mdat_sync_nxt = {mdat_sync_r[0], MOD_DATA};
        mclk_prev_nxt = mclk_sync_r[1];
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mclk_sync_r <= 2'h0;
            mdat_sync_r <= 2'h0;
            mclk_prev_r <= 1'b0;
        end else begin
            mclk_sync_r <= mclk_sync_nxt;
            mdat_sync_r <= mdat_sync_nxt;
            mclk_prev_r <= mclk_prev_nxt;
        end
    end

    assign mod_edge = mclk_sync_r[1] & ~mclk_prev_r;

    // Filters
    sdfmon_sinc_t cmp_r, cmp_nxt, pri_r, pri_nxt;
    logic [DATA_W-1:0] cmp_data_r, cmp_data_nxt, pri_data_r, pri_data_nxt;
    logic [DATA_W-1:0] cmp_prev_r, cmp_prev_nxt;
    logic pri_valid_r, pri_valid_nxt, cmp_new_r, cmp_new_nxt;
    logic cmp_done, pri_done;
    logic [31:0] cmp_res, pri_res;
    sdfmon_sinc_t cmp_tmp, pri_tmp;

    always_comb begin
        cmp_tmp = sinc_step(cmp_r, mdat_sync_r[1], CMP_CFG, cmp_done, cmp_res);
        pri_tmp = sinc_step(pri_r, mdat_sync_r[1], PRI_CFG, pri_done, pri_res);
        cmp_nxt = cmp_r;
        pri_nxt = pri_r;
        cmp_data_nxt = cmp_data_r;
        cmp_prev_nxt = cmp_prev_r;
        pri_data_nxt = pri_data_r;
        pri_valid_nxt = 1'b0;
        cmp_new_nxt = 1'b0;
        if (mod_edge) begin
            cmp_nxt = cmp_tmp;
            pri_nxt = pri_tmp;
            if (cmp_done) begin
                cmp_prev_nxt = cmp_data_r;
                cmp_data_nxt = cmp_res[DATA_W-1:0];
                cmp_new_nxt = 1'b1;
            end
            if (pri_done) begin
                pri_data_nxt = pri_res[DATA_W-1:0];
                pri_valid_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cmp_r <= '0;
            pri_r <= '0;
            cmp_data_r <= THR_MIN;
            cmp_prev_r <= THR_MIN;
            pri_data_r <= THR_MIN;
            pri_valid_r <= 1'b0;
            cmp_new_r <= 1'b0;
        end else begin
            cmp_r <= cmp_nxt;
            pri_r <= pri_nxt;
            cmp_data_r <= cmp_data_nxt;
            cmp_prev_r <= cmp_prev_nxt;
            pri_data_r <= pri_data_nxt;
            pri_valid_r <= pri_valid_nxt;
            cmp_new_r <= cmp_new_nxt;
        end
    end

    // Clock-fail counter and sticky flags
    logic [8:0]       miss_r, miss_nxt;
    logic [NFLAG-1:0] flag_r, flag_nxt, ev;
    logic             force_irq, irq_r, irq_nxt;
    logic             zc;

    always_comb begin
        force_irq = (THR.high == THR_MIN) && (THR.low == THR_MAX);
        zc = ((cmp_prev_r < THR.zero) != (cmp_data_r < THR.zero));
        miss_nxt = miss_r;
        if (mod_edge) begin
            miss_nxt = 9'h000;
        end else if (miss_r != CLKFAIL_LAST + 9'h001) begin
            miss_nxt = miss_r + 9'h001;
        end
        ev = '0;
        ev[FLAG_HI] = cmp_new_r && (cmp_data_r > THR.high);
        ev[FLAG_LO] = cmp_new_r && (cmp_data_r < THR.low);
        ev[FLAG_ZC] = cmp_new_r && zc;
        ev[FLAG_CF] = (miss_r == CLKFAIL_LAST) && !mod_edge;
        flag_nxt = (flag_r & ~FLAG_CLR) | ev;
        irq_nxt = |(flag_nxt & FLAG_EN) || force_irq;
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            miss_r <= 9'h000;
            flag_r <= '0;
            irq_r <= 1'b0;
        end else begin
            miss_r <= miss_nxt;
            flag_r <= flag_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign FLAG = flag_r;
    assign CMP_DATA = cmp_data_r;
    assign PRI_DATA = pri_data_r;
    assign PRI_VALID = pri_valid_r;
    assign IRQ = irq_r;

    // Checks
    a_clkfail_count: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        (miss_r == CLKFAIL_LAST) && !mod_edge |=> flag_r[FLAG_CF])
        else $error("clock fail flag missing");
    a_force_irq: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        force_irq |=> IRQ)
        else $error("forced interrupt missing");
    a_high_flag: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        cmp_new_r && (cmp_data_r > THR.high) |=> flag_r[FLAG_HI])
        else $error("high flag missing");
    a_low_irq: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        cmp_new_r && (cmp_data_r < THR.low) && FLAG_EN[FLAG_LO]
        |=> IRQ)
        else $error("low limit interrupt missing");
    a_flag_sticky: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        flag_r[FLAG_HI] && !FLAG_CLR[FLAG_HI] |=> flag_r[FLAG_HI])
        else $error("flag lost without clear");
    a_irq_follow: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        IRQ |-> ($past(force_irq) || |(flag_r & $past(FLAG_EN))))
        else $error("interrupt without cause");
    a_pri_valid: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        PRI_VALID |-> $past(mod_edge))
        else $error("primary result without edge");
    a_miss_reset: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        mod_edge |=> miss_r == 9'h000)
        else $error("miss counter not cleared");
    c_clkfail: cover property (@(posedge CORE_CLK) flag_r[FLAG_CF]);
    c_zero: cover property (@(posedge CORE_CLK) flag_r[FLAG_ZC]);
    c_pri: cover property (@(posedge CORE_CLK) PRI_VALID);
endmodule // sdfmon_top

// *** dv/sdfmon_mod_model.sv ***
// Behavioural sigma-delta modulator driving the monitor's link pins
`timescale 1ns/1ps
module sdfmon_mod_model (
    // Control from the bench
    input  wire logic run,
    input  wire logic bit_in,
    // Modulator link
    output logic      mod_clk,
    output logic      mod_data
);
    initial begin
        mod_clk  = 1'b0;
        mod_data = 1'b0;
    end
    // 400 ns period; clock stands still low while stopped
    always begin
        #200;
        mod_clk = run ? ~mod_clk : 1'b0;
        // Data moves on the falling edge; toggles while idle
        if (!mod_clk) begin
            mod_data = run ? bit_in : ~mod_data;
        end
    end
endmodule // sdfmon_mod_model

// *** dv/sdfmon_top_tb_top.sv ***
// Self-checking bench for the sigma-delta comparator monitor
`timescale 1ns/1ps
module sdfmon_top_tb_top;
    import sdfmon_pkg::*;
    logic                CORE_CLK, SYS_RST, run, bit_in, m_clk, m_dat;
    logic                pri_valid, irq;
    sdfmon_cfg_t         cfg;
    sdfmon_thr_t         thr;
    logic [NFLAG-1:0]    flag_en, flag_clr, flag;
    logic [DATA_W-1:0]   cmp_data, pri_data;
    int                  failures, samples_checked, cycles;
    logic [1:0]          ord_tab [4] = '{ORD_SINC1, ORD_SINC2, ORD_SINC3, 2'h3};
    logic [7:0]          osr_tab [4] = '{8'h0F, 8'h03, 8'h03, 8'h01};
    logic [15:0]         exp_tab [4] = '{16'h0010, 16'h0010, 16'h0040, 16'h0008};

    sdfmon_mod_model u_mod (.run(run), .bit_in(bit_in), .mod_clk(m_clk),
        .mod_data(m_dat));
    sdfmon_top u_dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .MOD_CLK(m_clk),
        .MOD_DATA(m_dat), .CMP_CFG(cfg), .PRI_CFG(cfg), .THR(thr),
        .FLAG_EN(flag_en), .FLAG_CLR(flag_clr), .FLAG(flag),
        .CMP_DATA(cmp_data), .PRI_DATA(pri_data), .PRI_VALID(pri_valid),
        .IRQ(irq));

    initial begin
        CORE_CLK = 1'b0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Waits for n result pulses, ends at a falling edge
    task automatic wait_res(input int n);
        repeat (n) begin
            do @(negedge CORE_CLK); while (pri_valid !== 1'b1);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask

    task automatic drive(input logic [1:0] o, input logic [7:0] r,
        input logic [47:0] t, input logic [3:0] en, input logic [3:0] clr);
        @(posedge CORE_CLK);
        cfg      <= '{order: o, osr: r};
        thr      <= t;
        flag_en  <= en;
        flag_clr <= clr;
    endtask

    initial begin
        SYS_RST = 1'b1;
        run = 1'b0;
        bit_in = 1'b1;
        cfg = '0;
        thr = {THR_MAX, THR_MIN, THR_MAX};
        flag_en = '0;
        flag_clr = '0;
        repeat (6) @(posedge CORE_CLK);
        SYS_RST <= 1'b0;
        run <= 1'b1;
        cyc(1);
        chk({11'h000, irq, flag}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            drive(ord_tab[i], osr_tab[i], {THR_MAX, THR_MIN, THR_MAX}, 4'h0, 4'h0);
            wait_res(6);
            chk(pri_data, exp_tab[i]);
            chk(cmp_data, exp_tab[i]);
            chk({12'h000, flag}, 16'h0000);
        end
        $display("test filter modes done");
        drive(ORD_SINC1, 8'h07, {16'h0005, 16'h0003, THR_MAX}, 4'hF, 4'hF);
        wait_res(4);
        drive(ORD_SINC1, 8'h07, {16'h0005, 16'h0003, THR_MAX}, 4'hF, 4'h0);
        wait_res(2);
        cyc(2);
        chk({11'h000, irq, flag}, 16'h0011);
        bit_in <= 1'b0;
        wait_res(4);
        cyc(2);
        chk({11'h000, irq, flag}, 16'h0013);
        drive(ORD_SINC1, 8'h07, {16'h0005, 16'h0003, 16'h0004}, 4'hF, 4'h0);
        bit_in <= 1'b1;
        wait_res(4);
        cyc(2);
        chk({11'h000, irq, flag}, 16'h0017);
        drive(ORD_SINC1, 8'h07, {THR_MAX, THR_MIN, THR_MAX}, 4'h0, 4'h0);
        cyc(3);
        chk({11'h000, irq, flag}, 16'h0007);
        drive(ORD_SINC1, 8'h07, {THR_MAX, THR_MIN, THR_MAX}, 4'h0, 4'hF);
        drive(ORD_SINC1, 8'h07, {THR_MAX, THR_MIN, THR_MAX}, 4'hF, 4'h0);
        cyc(3);
        chk({11'h000, irq, flag}, 16'h0000);
        $display("test thresholds done");
        drive(ORD_SINC1, 8'h07, {THR_MIN, THR_MAX, THR_MAX}, 4'h0, 4'h0);
        cyc(3);
        chk({15'h0000, irq}, 16'h0001);
        drive(ORD_SINC1, 8'h07, {THR_MAX, THR_MIN, THR_MAX}, 4'h0, 4'h0);
        drive(ORD_SINC1, 8'h07, {THR_MAX, THR_MIN, THR_MAX}, 4'h0, 4'hF);
        drive(ORD_SINC1, 8'h07, {THR_MAX, THR_MIN, THR_MAX}, 4'h8, 4'h0);
        cyc(3);
        chk({11'h000, irq, flag}, 16'h0000);
        $display("test forced interrupt done");
        run <= 1'b0;
        cyc(200);
        chk({11'h000, irq, flag}, 16'h0000);
        cyc(70);
        chk({11'h000, irq, flag}, 16'h0018);
        run <= 1'b1;
        drive(ORD_SINC1, 8'h07, {THR_MAX, THR_MIN, THR_MAX}, 4'h8, 4'hF);
        drive(ORD_SINC1, 8'h07, {THR_MAX, THR_MIN, THR_MAX}, 4'h8, 4'h0);
        cyc(150);
        chk({11'h000, irq, flag}, 16'h0000);
        $display("test clock fail done");
        end_of_test();
    end
endmodule // sdfmon_top_tb_top
